// [include/fuse_loader_defines.svh]
// Offsets, field positions and codes of the fuse and signature area
`ifndef FUSE_LOADER_DEFINES_SVH
`define FUSE_LOADER_DEFINES_SVH

// Fuse and signature areas, processor byte addresses
`define OFS_WDT_FUSE 6'h00
`define OFS_BOD_FUSE 6'h01
`define OFS_OSC_FUSE 6'h02
`define OFS_SERIAL_FIRST 6'h03
`define OFS_SERIAL_LAST 6'h0C
`define OFS_PWM_FUSE 6'h04
`define OFS_SYSA_FUSE 6'h05
`define OFS_SYSB_FUSE 6'h06
`define OFS_APPLICATION_END_FUSE_FUSE 6'h07
`define OFS_BOOT_END_FUSE_FUSE 6'h08
`define OFS_LOCK_FUSE 6'h0A
`define OFS_ERR_LOW_V 6'h22
`define OFS_ERR_HIGH_V 6'h23
// Processor window select: fuse area or signature area
`define SEL_SIGNATURE 1'h1
`define SEL_FUSE 1'h0
// Own-choice oscillator calibration and load status registers, in the fuse window
`define OFS_OSC_CAL_A 6'h30
`define OFS_OSC_CAL_B 6'h31
`define OFS_LOAD_STATUS 6'h32

// Field positions
`define WDT_WINDOW_HI 7
`define WDT_WINDOW_LO 4
`define WDT_PERIOD_HI 3
`define WDT_PERIOD_LO 0
`define BOD_LVL_HI 7
`define BOD_LVL_LO 5
`define BOD_SAMP_BIT 4
`define BOD_ACT_HI 3
`define BOD_ACT_LO 2
`define BOD_SLP_HI 1
`define BOD_SLP_LO 0
`define OSC_LOCK_BIT 7
`define OSC_FSEL_HI 1
`define OSC_FSEL_LO 0

// Codes
`define FSEL_16MHZ 2'h1
`define BOD_SLEEP_RSVD 2'h3
`define BOD_LVL_LOW_CODE 3'h2
`define BOD_LVL_HIGH_CODE 3'h7
`define SERIAL_BYTES 10
`define BYTE_ZERO 8'h00

`endif

// [include/fuse_loader_pkg.sv]
// Types shared by the fuse and signature loader
package fuse_loader_pkg;

  typedef struct packed {
    logic [3:0] window;
    logic [3:0] period;
  } wdt_ctrl_t;

  typedef struct packed {
    logic [2:0] threshold_level;
    logic sample_rate_select;
    logic [1:0] active_mode;
    logic [1:0] sleep_mode;
  } bod_ctrl_t;

  typedef struct packed {
    logic [5:0] coarse_calibration;
    logic calibration_lock;
    logic [3:0] temperature_calibration;
  } osc_cal_t;

  typedef struct packed {
    logic [5:0] addr;
    logic sel;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_LOAD,
    ST_DONE
  } load_state_t;

endpackage

// [verilog/fuse_signature_config_loader.sv]
// Fuse and signature area with reset-time copy into peripheral control fields
`timescale 1ns/1ns
`include "fuse_loader_defines.svh"

module fuse_signature_config_loader
  import fuse_loader_pkg::*;
#(
  parameter logic [5:0] CAL_COARSE_16M = 6'h20, // Factory coarse trim, arbitrary
  parameter logic [3:0] CAL_TEMP_16M = 4'h8 // Factory temperature trim, arbitrary
) (
  input wire logic clk_i, // System clock, 50 MHz
  input wire logic srst_i, // Synchronous reset, any source
  input wire logic por_i, // Reset was a power-on reset
  input wire logic [7:0] wdt_fuse_i, // Nonvolatile watchdog fuse byte
  input wire logic [7:0] bod_fuse_i, // Nonvolatile brown-out fuse byte
  input wire logic [7:0] osc_fuse_i, // Nonvolatile oscillator fuse byte
  input wire logic [7:0] pwm_fuse_i, // Nonvolatile timer fault fuse byte
  input wire logic [7:0] sysa_fuse_i, // Nonvolatile system fuse A
  input wire logic [7:0] sysb_fuse_i, // Nonvolatile system fuse B
  input wire logic [7:0] application_end_fuse_fuse_i, // Nonvolatile application end fuse
  input wire logic [7:0] boot_end_fuse_fuse_i, // Nonvolatile boot end fuse
  input wire logic [7:0] lock_fuse_i, // Nonvolatile lock key fuse
  input wire logic [79:0] serial_i, // Factory serial number, byte 0 low
  input wire logic [7:0] err_low_v_i, // Factory error at 3V
  input wire logic [7:0] err_high_v_i, // Factory error at 5V
  input wire logic [5:0] addr_i, // Register byte address
  input wire logic sel_i, // 1 signature area, 0 fuse area
  input wire logic [7:0] wdata_i, // Write data
  input wire logic wr_i, // Write strobe
  input wire logic rd_i, // Read strobe
  output logic [7:0] rdata_o, // Read data, cycle after strobe
  output wdt_ctrl_t wdt_ctrl_o, // Watchdog first control fields
  output bod_ctrl_t bod_ctrl_o, // Brown-out control fields
  output osc_cal_t osc_cal_o, // Main oscillator calibration
  output logic osc_16m_o, // Oscillator runs at 16 MHz
  output logic periph_rst_o // Hold peripherals in reset until loaded
);

  ////////////////////////////////////////////////////////////////////////////
  // Request bundling
  reg_req_t req;
  assign req = '{addr: addr_i, sel: sel_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  ////////////////////////////////////////////////////////////////////////////
  // Load sequencer
  load_state_t state_q, state_d;
  logic por_seen_q, por_seen_d;
  logic periph_rst_q, periph_rst_d;
  wdt_ctrl_t wdt_q, wdt_d;
  bod_ctrl_t bod_q, bod_d;
  osc_cal_t cal_q, cal_d;
  logic fast_q, fast_d;
  logic cal_wr_ok;

  // Calibration writable only while unlocked and after the load
  assign cal_wr_ok = !cal_q.calibration_lock && state_q == ST_DONE;

  always_comb begin
    state_d = state_q;
    por_seen_d = por_seen_q;
    periph_rst_d = periph_rst_q;
    wdt_d = wdt_q;
    bod_d = bod_q;
    cal_d = cal_q;
    fast_d = fast_q;
    unique case (state_q)
      ST_IDLE: begin
        state_d = ST_LOAD;
      end
      ST_LOAD: begin
        // Single load cycle at end of start-up
        wdt_d.window = wdt_fuse_i[`WDT_WINDOW_HI:`WDT_WINDOW_LO];
        wdt_d.period = wdt_fuse_i[`WDT_PERIOD_HI:`WDT_PERIOD_LO];
        if (por_seen_q) begin
          bod_d.threshold_level = bod_fuse_i[`BOD_LVL_HI:`BOD_LVL_LO];
          bod_d.sample_rate_select = bod_fuse_i[`BOD_SAMP_BIT];
          bod_d.active_mode = bod_fuse_i[`BOD_ACT_HI:`BOD_ACT_LO];
          bod_d.sleep_mode = bod_fuse_i[`BOD_SLP_HI:`BOD_SLP_LO];
        end
        cal_d.calibration_lock = osc_fuse_i[`OSC_LOCK_BIT];
        fast_d = osc_fuse_i[`OSC_FSEL_HI:`OSC_FSEL_LO] == `FSEL_16MHZ;
        // Only the 16 MHz trim exists; reserved codes still get it
        cal_d.coarse_calibration = CAL_COARSE_16M;
        cal_d.temperature_calibration = CAL_TEMP_16M;
        por_seen_d = 1'b0;
        state_d = ST_DONE;
      end
      ST_DONE: begin
        periph_rst_d = 1'b0;
        if (req.wr && req.sel == `SEL_FUSE && cal_wr_ok) begin
          if (req.addr == `OFS_OSC_CAL_A) begin
            cal_d.coarse_calibration = req.wdata[5:0];
          end
          if (req.addr == `OFS_OSC_CAL_B) begin
            cal_d.temperature_calibration = req.wdata[3:0];
          end
        end
      end
    endcase
    // Power-on flag caught while reset is held, kept until a load uses it
    // A warm reset in the middle of a load must not lose a pending power-on
    if (srst_i) begin
      por_seen_d = por_i ? 1'b1 : por_seen_q;
    end
  end

  // Brown-out fields keep their value through non power-on resets
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_q <= ST_IDLE;
      periph_rst_q <= 1'b1;
      wdt_q <= '0;
      cal_q <= '0;
      fast_q <= 1'b0;
    end else begin
      state_q <= state_d;
      periph_rst_q <= periph_rst_d;
      wdt_q <= wdt_d;
      cal_q <= cal_d;
      fast_q <= fast_d;
    end
    bod_q <= bod_d;
    por_seen_q <= por_seen_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port; fuse bytes have no write path at all
  logic [7:0] rdata_q, rdata_d;
  logic [5:0] ser_idx;

  assign ser_idx = req.addr - `OFS_SERIAL_FIRST;

  always_comb begin
    rdata_d = `BYTE_ZERO;
    if (req.rd) begin
      if (req.sel == `SEL_SIGNATURE) begin
        if (req.addr >= `OFS_SERIAL_FIRST && req.addr <= `OFS_SERIAL_LAST) begin
          rdata_d = serial_i[ser_idx[3:0]*8 +: 8];
        end else if (req.addr == `OFS_ERR_LOW_V) begin
          rdata_d = err_low_v_i;
        end else if (req.addr == `OFS_ERR_HIGH_V) begin
          rdata_d = err_high_v_i;
        end
      end else begin
        unique case (req.addr)
          `OFS_WDT_FUSE: rdata_d = wdt_fuse_i;
          `OFS_BOD_FUSE: rdata_d = bod_fuse_i;
          `OFS_OSC_FUSE: rdata_d = osc_fuse_i;
          `OFS_PWM_FUSE: rdata_d = pwm_fuse_i;
          `OFS_SYSA_FUSE: rdata_d = sysa_fuse_i;
          `OFS_SYSB_FUSE: rdata_d = sysb_fuse_i;
          `OFS_APPLICATION_END_FUSE_FUSE: rdata_d = application_end_fuse_fuse_i;
          `OFS_BOOT_END_FUSE_FUSE: rdata_d = boot_end_fuse_fuse_i;
          `OFS_LOCK_FUSE: rdata_d = lock_fuse_i;
          `OFS_OSC_CAL_A: rdata_d = {2'h0, cal_q.coarse_calibration};
          `OFS_OSC_CAL_B: rdata_d = {cal_q.calibration_lock, 3'h0,
                                     cal_q.temperature_calibration};
          `OFS_LOAD_STATUS: rdata_d = {6'h00, fast_q, state_q == ST_DONE};
          default: rdata_d = `BYTE_ZERO;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rdata_q <= `BYTE_ZERO;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata_o = rdata_q;
  assign wdt_ctrl_o = wdt_q;
  assign bod_ctrl_o = bod_q;
  assign osc_cal_o = cal_q;
  assign osc_16m_o = fast_q;
  assign periph_rst_o = periph_rst_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  // Watchdog fields
  a_wdt_window_load: assert property (
    @(posedge clk_i) disable iff (srst_i)
    state_q == ST_LOAD
    |=> wdt_ctrl_o.window == $past(wdt_fuse_i[`WDT_WINDOW_HI:`WDT_WINDOW_LO]))
    else $error("watchdog window not loaded");
  a_wdt_period_load: assert property (
    @(posedge clk_i) disable iff (srst_i)
    state_q == ST_LOAD
    |=> wdt_ctrl_o.period == $past(wdt_fuse_i[`WDT_PERIOD_HI:`WDT_PERIOD_LO]))
    else $error("watchdog period not loaded");
  a_wdt_held_after: assert property (
    @(posedge clk_i) disable iff (srst_i)
    state_q == ST_DONE
    |=> $stable(wdt_ctrl_o))
    else $error("watchdog fields moved after load");

  // Brown-out fields, reloaded only after power-on
  a_bod_keep_warm: assert property (
    @(posedge clk_i) disable iff (srst_i)
    state_q == ST_LOAD && !por_seen_q
    |=> $stable(bod_ctrl_o))
    else $error("brown-out changed on warm reset");
  a_bod_por_load: assert property (
    @(posedge clk_i) disable iff (srst_i)
    state_q == ST_LOAD && por_seen_q
    |=> bod_ctrl_o == $past(bod_fuse_i))
    else $error("brown-out not loaded after power-on");
  a_bod_level_load: assert property (
    @(posedge clk_i) disable iff (srst_i)
    state_q == ST_LOAD && por_seen_q
    |=> bod_ctrl_o.threshold_level == $past(bod_fuse_i[`BOD_LVL_HI:`BOD_LVL_LO]))
    else $error("brown-out level not loaded");
  a_bod_sample_load: assert property (
    @(posedge clk_i) disable iff (srst_i)
    state_q == ST_LOAD && por_seen_q
    |=> bod_ctrl_o.sample_rate_select == $past(bod_fuse_i[`BOD_SAMP_BIT]))
    else $error("brown-out sample rate not loaded");
  a_bod_active_load: assert property (
    @(posedge clk_i) disable iff (srst_i)
    state_q == ST_LOAD && por_seen_q
    |=> bod_ctrl_o.active_mode == $past(bod_fuse_i[`BOD_ACT_HI:`BOD_ACT_LO]))
    else $error("brown-out active mode not loaded");
  a_bod_sleep_load: assert property (
    @(posedge clk_i) disable iff (srst_i)
    state_q == ST_LOAD && por_seen_q
    |=> bod_ctrl_o.sleep_mode == $past(bod_fuse_i[`BOD_SLP_HI:`BOD_SLP_LO]))
    else $error("brown-out sleep mode not loaded");

  // Oscillator calibration and lock
  a_lock_load: assert property (
    @(posedge clk_i) disable iff (srst_i)
    state_q == ST_LOAD
    |=> osc_cal_o.calibration_lock == $past(osc_fuse_i[`OSC_LOCK_BIT]))
    else $error("lock bit not loaded");
  a_cal_locked: assert property (
    @(posedge clk_i) disable iff (srst_i)
    state_q == ST_DONE && osc_cal_o.calibration_lock
    |=> $stable(osc_cal_o))
    else $error("locked calibration changed");
  a_cal_open_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    state_q == ST_DONE && !osc_cal_o.calibration_lock && wr_i && sel_i == `SEL_FUSE
    && addr_i == `OFS_OSC_CAL_A |=> osc_cal_o.coarse_calibration == $past(wdata_i[5:0]))
    else $error("unlocked coarse trim not written");
  a_cal_open_b: assert property (
    @(posedge clk_i) disable iff (srst_i)
    state_q == ST_DONE && !osc_cal_o.calibration_lock && wr_i && sel_i == `SEL_FUSE
    && addr_i == `OFS_OSC_CAL_B |=> osc_cal_o.temperature_calibration == $past(wdata_i[3:0]))
    else $error("unlocked temperature trim not written");
  a_freq_sel: assert property (
    @(posedge clk_i) disable iff (srst_i)
    state_q == ST_LOAD
    |=> osc_16m_o == ($past(osc_fuse_i[`OSC_FSEL_HI:`OSC_FSEL_LO]) == `FSEL_16MHZ))
    else $error("frequency select wrong");
  a_freq_held: assert property (
    @(posedge clk_i) disable iff (srst_i)
    state_q == ST_DONE
    |=> $stable(osc_16m_o))
    else $error("frequency select moved after load");
  a_coarse_load: assert property (
    @(posedge clk_i) disable iff (srst_i)
    state_q == ST_LOAD
    |=> osc_cal_o.coarse_calibration == CAL_COARSE_16M)
    else $error("factory coarse trim not loaded");
  a_temp_load: assert property (
    @(posedge clk_i) disable iff (srst_i)
    state_q == ST_LOAD
    |=> osc_cal_o.temperature_calibration == CAL_TEMP_16M)
    else $error("factory temperature trim not loaded");

  // Load sequence and peripheral release
  a_load_follows: assert property (
    @(posedge clk_i) disable iff (srst_i)
    state_q == ST_IDLE
    |=> state_q == ST_LOAD)
    else $error("load did not follow reset");
  a_done_stays: assert property (
    @(posedge clk_i) disable iff (srst_i)
    state_q == ST_DONE
    |=> state_q == ST_DONE)
    else $error("load ran twice");
  a_release_order: assert property (
    @(posedge clk_i) disable iff (srst_i)
    $fell(periph_rst_o)
    |-> $past(state_q, 2) == ST_LOAD)
    else $error("peripherals released before load");
  a_held_loading: assert property (
    @(posedge clk_i) disable iff (srst_i)
    state_q != ST_DONE
    |-> periph_rst_o)
    else $error("peripherals free during load");
  a_held_in_reset: assert property (
    @(posedge clk_i)
    srst_i
    |=> periph_rst_o)
    else $error("peripherals free during reset");

  // Read port
  a_serial_read: assert property (
    @(posedge clk_i) disable iff (srst_i)
    rd_i && sel_i == `SEL_SIGNATURE && addr_i == `OFS_SERIAL_FIRST
    |=> rdata_o == $past(serial_i[7:0]))
    else $error("serial byte 0 wrong");
  a_serial_last: assert property (
    @(posedge clk_i) disable iff (srst_i)
    rd_i && sel_i == `SEL_SIGNATURE && addr_i == `OFS_SERIAL_LAST
    |=> rdata_o == $past(serial_i[`SERIAL_BYTES*8-1 -: 8]))
    else $error("serial byte 9 wrong");
  a_err_low_read: assert property (
    @(posedge clk_i) disable iff (srst_i)
    rd_i && sel_i == `SEL_SIGNATURE && addr_i == `OFS_ERR_LOW_V
    |=> rdata_o == $past(err_low_v_i))
    else $error("low voltage error byte wrong");
  a_err_high_read: assert property (
    @(posedge clk_i) disable iff (srst_i)
    rd_i && sel_i == `SEL_SIGNATURE && addr_i == `OFS_ERR_HIGH_V
    |=> rdata_o == $past(err_high_v_i))
    else $error("high voltage error byte wrong");
  a_wdt_fuse_read: assert property (
    @(posedge clk_i) disable iff (srst_i)
    rd_i && sel_i == `SEL_FUSE && addr_i == `OFS_WDT_FUSE
    |=> rdata_o == $past(wdt_fuse_i))
    else $error("watchdog fuse read wrong");
  a_lock_fuse_read: assert property (
    @(posedge clk_i) disable iff (srst_i)
    rd_i && sel_i == `SEL_FUSE && addr_i == `OFS_LOCK_FUSE
    |=> rdata_o == $past(lock_fuse_i))
    else $error("lock key fuse read wrong");
  a_rdata_idle: assert property (
    @(posedge clk_i) disable iff (srst_i)
    !rd_i
    |=> rdata_o == `BYTE_ZERO)
    else $error("read data outside its cycle");

endmodule // fuse_signature_config_loader

// [tb/fuse_store_model.sv]
// Behavioural nonvolatile fuse and signature store
`timescale 1ns/1ns

module fuse_store_model (
  input wire logic clk_i, // System clock
  input wire logic prog_i, // Program strobe, debug pin path
  input wire logic [127:0] image_i, // New image
  output logic [127:0] store_o // Stored image, static levels
);
  logic [127:0] store_q = '0;

  // Processor has no path in here, only the debug pin strobe
  always_ff @(posedge clk_i) begin
    if (prog_i) begin
      store_q <= image_i;
    end
  end
  assign store_o = store_q;
endmodule // fuse_store_model

// [tb/testbench.sv]
// Self-checking bench for the fuse and signature loader
`timescale 1ns/1ns

module testbench;
  import fuse_loader_pkg::*;
  localparam logic [5:0] COARSE = 6'h15;
  localparam logic [3:0] TEMP = 4'h3;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic por_i = 1'b1;
  logic sel_i = 1'b0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic rd_q = 1'b0;
  logic prog = 1'b0;
  logic [5:0] addr_i = 6'h00;
  logic [7:0] wdata_i = 8'h00;
  logic [7:0] rdata_o;
  logic [127:0] img = '0;
  logic [127:0] st;
  wdt_ctrl_t wdt_ctrl_o;
  bod_ctrl_t bod_ctrl_o;
  osc_cal_t osc_cal_o;
  logic osc_16m_o;
  logic periph_rst_o;
  int n_errors = 0;
  int compares = 0;
  logic [7:0] exp_q[$];
  string name_q[$];

  always #10 clk_i = ~clk_i;

  fuse_store_model store (.clk_i(clk_i), .prog_i(prog), .image_i(img), .store_o(st));

  fuse_signature_config_loader #(.CAL_COARSE_16M(COARSE), .CAL_TEMP_16M(TEMP)) dut (
    .clk_i(clk_i), .srst_i(srst_i), .por_i(por_i), .wdt_fuse_i(st[7:0]),
    .bod_fuse_i(st[15:8]), .osc_fuse_i(st[23:16]), .pwm_fuse_i(8'hA1),
    .sysa_fuse_i(8'hC4), .sysb_fuse_i(8'h07), .application_end_fuse_fuse_i(8'h10),
    .boot_end_fuse_fuse_i(8'h04), .lock_fuse_i(st[31:24]), .serial_i(st[111:32]),
    .err_low_v_i(st[119:112]), .err_high_v_i(st[127:120]), .addr_i(addr_i),
    .sel_i(sel_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .wdt_ctrl_o(wdt_ctrl_o), .bod_ctrl_o(bod_ctrl_o), .osc_cal_o(osc_cal_o),
    .osc_16m_o(osc_16m_o), .periph_rst_o(periph_rst_o));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic final_report;
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Read data stands one cycle only, so it is taken mid-cycle
  always @(posedge clk_i) rd_q <= rd_i;
  always @(negedge clk_i) begin
    if (rd_q) begin
      check(name_q.pop_front(), {8'h00, rdata_o}, {8'h00, exp_q.pop_front()});
    end
  end

  task automatic wr(logic [5:0] a, logic s, logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    sel_i <= s;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(logic [5:0] a, logic s, logic [7:0] e, string nm);
    @(posedge clk_i);
    addr_i <= a;
    sel_i <= s;
    rd_i <= 1'b1;
    exp_q.push_back(e);
    name_q.push_back(nm);
    @(posedge clk_i);
    rd_i <= 1'b0;
  endtask

  // Fuses change only under reset, as a real part would see them
  task automatic boot(logic por, logic [127:0] image);
    int k;
    @(posedge clk_i);
    prog <= 1'b1;
    img <= image;
    srst_i <= 1'b1;
    por_i <= por;
    @(posedge clk_i);
    prog <= 1'b0;
    repeat (4) @(posedge clk_i);
    srst_i <= 1'b0;
    por_i <= 1'b0;
    k = 0;
    @(negedge clk_i);
    while (periph_rst_o !== 1'b0 && k < 20) begin
      @(negedge clk_i);
      k++;
    end
    check("release", 16'(k < 20), 16'h0001);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] wdt;
    logic [7:0] brownout_detector;
    logic [7:0] osc;
    logic [7:0] lk;
    logic [79:0] ser;
    logic [15:0] err;
    void'($urandom(87));
    for (int i = 0; i < 4; i++) begin
      wdt = 8'($urandom);
      lk = 8'($urandom);
      ser = 80'({$urandom, $urandom, $urandom});
      err = 16'($urandom);
      brownout_detector = {(i[0] ? 3'h7 : 3'h2), i[0], i[1:0], (i == 3) ? 2'h2 : i[1:0]};
      osc = {i[0], 5'h00, (i == 3) ? 2'h2 : 2'h1};
      boot(1'b1, {err, ser, lk, osc, brownout_detector, wdt});
      check("wdt", 16'(wdt_ctrl_o), 16'(wdt));
      check("bod", 16'(bod_ctrl_o), 16'(brownout_detector));
      check("osc", 16'(osc_cal_o), 16'({COARSE, osc[7], TEMP}));
      check("freq", 16'(osc_16m_o), 16'(i != 3));
      for (int j = 0; j < 10; j++) begin
        rd(6'(6'h03 + j), 1'b1, ser[8*j+:8], "serial");
      end
      rd(6'h22, 1'b1, err[7:0], "err_low");
      rd(6'h23, 1'b1, err[15:8], "err_high");
      wr(6'h03, 1'b1, ~ser[7:0]);
      rd(6'h03, 1'b1, ser[7:0], "serial_wr");
      wr(6'h00, 1'b0, ~wdt);
      rd(6'h00, 1'b0, wdt, "wdt_wr");
      rd(6'h0A, 1'b0, lk, "lock_key");
      rd(6'h0D, 1'b1, 8'h00, "unmapped");
      wr(6'h30, 1'b0, {2'b00, ~COARSE});
      rd(6'h30, 1'b0, {2'b00, osc[7] ? COARSE : ~COARSE}, "cal_a");
      wr(6'h31, 1'b0, {4'h0, ~TEMP});
      rd(6'h31, 1'b0, {osc[7], 3'h0, osc[7] ? TEMP : ~TEMP}, "cal_b");
      rd(6'h04, 1'b0, 8'hA1, "pwm_fuse");
      rd(6'h32, 1'b0, {6'h00, 1'(i != 3), 1'b1}, "status");
      $display("test load %0d done", i);
    end
    // Warm reset must keep brown-out settings, power-on must refresh them
    boot(1'b0, {err, ser, lk, 8'h01, 8'h45, 8'h3C});
    check("bod_warm", 16'(bod_ctrl_o), 16'(brownout_detector));
    check("wdt_warm", 16'(wdt_ctrl_o), 16'h003C);
    boot(1'b1, {err, ser, lk, 8'h01, 8'h45, 8'h3C});
    check("bod_por", 16'(bod_ctrl_o), 16'h0045);
    $display("test reset kinds done");
    repeat (2) @(posedge clk_i);
    final_report();
  end

  initial begin
    #200000;
    n_errors++;
    final_report();
  end
endmodule // testbench
